// >>> src/hcis_map.svh
// Register codes, field positions and reset values of the processor event block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef HCIS_MAP_SVH
`define HCIS_MAP_SVH

// Command codes on the host port
`define HCIS_CMD_STATUS_RD    8'h24
`define HCIS_CMD_STATUS_WR    8'hA4
`define HCIS_CMD_MASK_RD      8'h25
`define HCIS_CMD_MASK_WR      8'hA5

// Field positions inside both registers
`define HCIS_BIT_FRAME_ISO    0
`define HCIS_BIT_ASYNC_LIST   1
`define HCIS_BIT_XFER_DONE    2
`define HCIS_BIT_OP_REGISTER  4
`define HCIS_BIT_SUSPENDED    5
`define HCIS_BIT_CLOCK_READY  6

// Implemented bits; bit 3 and bits 15..7 read as zero
`define HCIS_FLAG_BITS        7'h77
`define HCIS_STATUS_RESET     7'h00
`define HCIS_MASK_RESET       7'h00
`define HCIS_REG_WIDTH        16
`define HCIS_FLAG_WIDTH       7

`endif

// >>> src/hcis_pkg.sv
// Types shared by the processor event block and its byte counter.
// Assumes hcis_map.svh is on the include path.
`include "hcis_map.svh"

package hcis_pkg;

    typedef logic [`HCIS_FLAG_WIDTH-1:0] hcis_flags_t;

    typedef enum logic {
        HCIS_TRIG_LEVEL = 1'b0,
        HCIS_TRIG_EDGE  = 1'b1
    } hcis_trig_t;

    typedef enum logic [1:0] {
        HCIS_CNT_IDLE  = 2'b00,
        HCIS_CNT_COUNT = 2'b01
    } hcis_cnt_state_t;

endpackage

// >>> src/hcis_byte_counter.sv
// Counts transferred bytes and flags the internal end of transfer.
// Assumes start and byte strobes come from logic on the same clock.
`timescale 1ns/1ps
`include "hcis_map.svh"

module hcis_byte_counter #(
    parameter int CNT_WIDTH = 16
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Transfer control
    input  wire logic                 xfer_start,
    input  wire logic                 byte_strobe,
    input  wire logic [CNT_WIDTH-1:0] byte_count_limit,
    // Result
    output logic                      end_pulse
);

    hcis_pkg::hcis_cnt_state_t state;
    logic [CNT_WIDTH-1:0]      count;
    logic [CNT_WIDTH-1:0]      limit;
    logic [CNT_WIDTH-1:0]      next_count;
    logic                      hit;

    assign next_count = count + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
    assign hit        = (state == hcis_pkg::HCIS_CNT_COUNT) && byte_strobe
                        && (next_count == limit);

    ////////////////////////////////////////////////////////////////////////
    // A zero limit never starts counting, so no spurious end is reported
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= hcis_pkg::HCIS_CNT_IDLE;
            count <= '0;
            limit <= '0;
        end else begin
            case (state)
                hcis_pkg::HCIS_CNT_IDLE: begin
                    if (xfer_start && (byte_count_limit != '0)) begin
                        state <= hcis_pkg::HCIS_CNT_COUNT;
                        count <= '0;
                        limit <= byte_count_limit;
                    end
                end
                hcis_pkg::HCIS_CNT_COUNT: begin
                    if (hit) begin
                        state <= hcis_pkg::HCIS_CNT_IDLE;
                    end else if (byte_strobe) begin
                        count <= next_count;
                    end
                end
                default: begin
                    state <= hcis_pkg::HCIS_CNT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            end_pulse <= 1'b0;
        end else begin
            end_pulse <= hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    count_end_a: assert property (@(posedge clk) disable iff (rst)
        hit |=> end_pulse ##1 !end_pulse)
        else $error("byte count reached without a single end pulse");

endmodule // hcis_byte_counter

// >>> src/hcis_event_ctrl.sv
// Processor event status, mask and interrupt pin logic of the host controller.
// Assumes event strobes are same-clock pulses; the external end pin is asynchronous.
//
// Overview of operation
// - Pin asserts only for unmasked flags with master enable
// - Reads keep flags; writing one clears a flag
// - Status codes 24/A4, bits 15..7 reserved, reset zero
// - Bit 6 sets when clock becomes ready
// - Bit 5 sets when host controller is suspended
// - Bit 4 sets on operational register event
// - Bit 2 sets on internal or external transfer end
// - Bit 1 sets when acknowledged list data waits
// - Bit 0 sets at each frame start mark
// - Mask codes 25/A5, bits match status bits
// - Mask resets to zero, pin stays quiet
// - Mask one passes a flag, zero blocks it
// - Master enable zero disables pin entirely
// - Edge select chooses level or edge pin signalling
// - Internal end when byte count reaches limit
`timescale 1ns/1ps
`include "hcis_map.svh"

module hcis_event_ctrl #(
    parameter int CNT_WIDTH = 16
) (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst,
    // Host port command access
    input  wire logic                           cmd_strobe,
    input  wire logic [7:0]                     cmd_code,
    input  wire logic [`HCIS_REG_WIDTH-1:0]     cmd_wdata,
    output logic [`HCIS_REG_WIDTH-1:0]          rd_data,
    output logic                                rd_valid,
    // Hardware setup bits
    input  wire logic                           irq_pin_master_enable,
    input  wire logic                           irq_pin_edge_select,
    // Event sources on this clock
    input  wire logic                           clock_ready_evt,
    input  wire logic                           host_suspended_evt,
    input  wire logic                           op_register_evt,
    input  wire logic                           async_list_evt,
    input  wire logic                           frame_iso_list_evt,
    // Transfer end sources
    input  wire logic                           end_of_transfer_pin,
    input  wire logic                           xfer_start,
    input  wire logic                           byte_strobe,
    input  wire logic [CNT_WIDTH-1:0]           byte_count_limit,
    // Interrupt pin and state
    output logic                                irq,
    output hcis_pkg::hcis_flags_t               cpu_event_status,
    output hcis_pkg::hcis_flags_t               cpu_event_mask
);

    hcis_pkg::hcis_flags_t set_vec;
    hcis_pkg::hcis_flags_t clr_vec;
    hcis_pkg::hcis_flags_t next_status;
    hcis_pkg::hcis_trig_t  trig_mode;
    logic                  wr_status;
    logic                  wr_mask;
    logic                  rd_status;
    logic                  rd_mask;
    logic                  internal_end;
    logic                  ext_sync1;
    logic                  ext_sync2;
    logic                  ext_prev;
    logic                  ext_end;
    logic                  transfer_done;
    logic                  irq_req;
    logic                  irq_req_q;

    ////////////////////////////////////////////////////////////////////////
    // Command decode
    assign wr_status = cmd_strobe && (cmd_code == `HCIS_CMD_STATUS_WR);
    assign wr_mask   = cmd_strobe && (cmd_code == `HCIS_CMD_MASK_WR);
    assign rd_status = cmd_strobe && (cmd_code == `HCIS_CMD_STATUS_RD);
    assign rd_mask   = cmd_strobe && (cmd_code == `HCIS_CMD_MASK_RD);

    ////////////////////////////////////////////////////////////////////////
    // Transfer end: internal counter or the external pin
    hcis_byte_counter #(
        .CNT_WIDTH        (CNT_WIDTH)
    ) u_byte_counter (
        .clk              (clk),
        .rst              (rst),
        .xfer_start       (xfer_start),
        .byte_strobe      (byte_strobe),
        .byte_count_limit (byte_count_limit),
        .end_pulse        (internal_end)
    );

    // Pin is asynchronous, so two stages before the edge detector
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev  <= 1'b0;
        end else begin
            ext_sync1 <= end_of_transfer_pin;
            ext_sync2 <= ext_sync1;
            ext_prev  <= ext_sync2;
        end
    end

    assign ext_end       = ext_sync2 && !ext_prev;
    assign transfer_done = internal_end || ext_end;

    ////////////////////////////////////////////////////////////////////////
    // Event status flags
    always_comb begin
        set_vec = '0;
        set_vec[`HCIS_BIT_CLOCK_READY] = clock_ready_evt;
        set_vec[`HCIS_BIT_SUSPENDED]   = host_suspended_evt;
        set_vec[`HCIS_BIT_OP_REGISTER] = op_register_evt;
        set_vec[`HCIS_BIT_XFER_DONE]   = transfer_done;
        set_vec[`HCIS_BIT_ASYNC_LIST]  = async_list_evt;
        set_vec[`HCIS_BIT_FRAME_ISO]   = frame_iso_list_evt;
    end

    // Reserved lanes are dropped, so a write of FF clears exactly the flags
    assign clr_vec = wr_status ? (cmd_wdata[`HCIS_FLAG_WIDTH-1:0] & `HCIS_FLAG_BITS)
                               : '0;
    // Set is applied after clear so a coincident event is kept
    assign next_status = (cpu_event_status & ~clr_vec) | set_vec;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_event_status <= `HCIS_STATUS_RESET;
        end else begin
            cpu_event_status <= next_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mask register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_event_mask <= `HCIS_MASK_RESET;
        end else if (wr_mask) begin
            cpu_event_mask <= cmd_wdata[`HCIS_FLAG_WIDTH-1:0] & `HCIS_FLAG_BITS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the command; other codes belong elsewhere
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data  <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_status || rd_mask;
            if (rd_status) begin
                rd_data <= {9'h000, cpu_event_status};
            end else if (rd_mask) begin
                rd_data <= {9'h000, cpu_event_mask};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pin
    assign irq_req   = irq_pin_master_enable
                       && (|(cpu_event_status & cpu_event_mask));
    assign trig_mode = hcis_pkg::hcis_trig_t'(irq_pin_edge_select);

    // Edge mode gives one pulse per rise of the request; a flag arriving while
    // the request is already high does not pulse again
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_req_q <= 1'b0;
            irq       <= 1'b0;
        end else begin
            irq_req_q <= irq_req;
            if (trig_mode == hcis_pkg::HCIS_TRIG_EDGE) begin
                irq <= irq_req && !irq_req_q;
            end else begin
                irq <= irq_req;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    pin_gate_a: assert property (@(posedge clk) disable iff (rst)
        !irq_pin_master_enable |=> !irq)
        else $error("interrupt pin driven while master enable is off");

    mask_block_a: assert property (@(posedge clk) disable iff (rst)
        ((cpu_event_status & cpu_event_mask) == '0) |=> !irq)
        else $error("interrupt pin driven with no unmasked flag");

    level_irq_a: assert property (@(posedge clk) disable iff (rst)
        (irq_req && !irq_pin_edge_select) |=> irq)
        else $error("level interrupt missing for an unmasked flag");

    edge_pulse_a: assert property (@(posedge clk) disable iff (rst)
        (irq && irq_pin_edge_select) |=> !irq)
        else $error("edge interrupt wider than one cycle");

    read_keeps_a: assert property (@(posedge clk) disable iff (rst)
        (!wr_status && (set_vec == '0)) |=> (cpu_event_status == $past(cpu_event_status)))
        else $error("flags changed without a clear or an event");

    clear_one_a: assert property (@(posedge clk) disable iff (rst)
        (wr_status && (set_vec == '0))
        |=> ((cpu_event_status & $past(cmd_wdata[6:0])) == '0))
        else $error("write of one did not clear the flag");

    set_wins_a: assert property (@(posedge clk) disable iff (rst)
        (set_vec != '0) |=> ((cpu_event_status & $past(set_vec)) == $past(set_vec)))
        else $error("event lost against a clear");

    mask_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_mask |=> (cpu_event_mask == ($past(cmd_wdata[6:0]) & 7'h77)))
        else $error("mask write not stored");

    mask_hold_a: assert property (@(posedge clk) disable iff (rst)
        !wr_mask |=> (cpu_event_mask == $past(cpu_event_mask)))
        else $error("mask changed without a write");

    reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
        rd_valid |-> ((rd_data[15:7] == 9'h000) && !rd_data[3]))
        else $error("reserved read bits not zero");

    ext_end_a: assert property (@(posedge clk) disable iff (rst)
        ($rose(end_of_transfer_pin) ##1 end_of_transfer_pin ##1 end_of_transfer_pin)
        |=> cpu_event_status[`HCIS_BIT_XFER_DONE])
        else $error("external transfer end did not set the flag");

    frame_set_a: assert property (@(posedge clk) disable iff (rst)
        frame_iso_list_evt |=> cpu_event_status[`HCIS_BIT_FRAME_ISO])
        else $error("frame event did not set its flag");

endmodule // hcis_event_ctrl

// >>> tb/hcis_host_model.sv
// Host processor model that issues command strobes on the register port.
// Assumes the block answers a read one cycle after the command is taken.
`timescale 1ns/1ps
`include "hcis_map.svh"

module hcis_host_model (
    // Clock
    input  wire logic        clk,
    // Command side
    output logic             cmd_strobe,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    // Read answer
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid
);
    initial begin
        cmd_strobe = 1'b0;
        cmd_code   = 8'h00;
        cmd_wdata  = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Lines are flipped after a command so a stale value never passes for a fresh one
    task automatic issue(input logic [7:0] code, input logic [15:0] data);
        @(posedge clk);
        #1;
        cmd_strobe = 1'b1;
        cmd_code   = code;
        cmd_wdata  = data;
        @(posedge clk);
        #1;
        cmd_strobe = 1'b0;
        cmd_code   = ~code;
        cmd_wdata  = ~data;
    endtask

    task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic ok);
        issue(code, 16'h0000);
        data = rd_data;
        ok   = rd_valid;
    endtask

    task automatic clear_all();
        issue(`HCIS_CMD_STATUS_WR, 16'h00FF);
    endtask
endmodule // hcis_host_model

// >>> tb/test_hcis_event_ctrl.sv
// Self-checking bench for the processor event status, mask and pin logic.
// Assumes the host model drives the command port; events come from here.
`timescale 1ns/1ps
`include "hcis_map.svh"

module test_hcis_event_ctrl;
    logic                  clk;
    logic                  rst;
    logic                  en;
    logic                  edge_sel;
    logic                  eot_pin;
    logic [6:0]            evt;
    logic [15:0]           limit;
    logic                  cmd_strobe;
    logic [7:0]            cmd_code;
    logic [15:0]           cmd_wdata;
    logic [15:0]           rd_data;
    logic                  rd_valid;
    logic                  irq;
    hcis_pkg::hcis_flags_t status;
    hcis_pkg::hcis_flags_t mask;
    int                    fails;
    int                    compares;

    // Expected flag for each event strobe index of evt
    function automatic logic [15:0] flag_of(input int i);
        case (i)
            0:       flag_of = 16'h0001 << `HCIS_BIT_CLOCK_READY;
            1:       flag_of = 16'h0001 << `HCIS_BIT_SUSPENDED;
            2:       flag_of = 16'h0001 << `HCIS_BIT_OP_REGISTER;
            3:       flag_of = 16'h0001 << `HCIS_BIT_ASYNC_LIST;
            4:       flag_of = 16'h0001 << `HCIS_BIT_FRAME_ISO;
            default: flag_of = 16'h0000;
        endcase
    endfunction

    hcis_host_model host (.clk(clk), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));

    hcis_event_ctrl #(.CNT_WIDTH(16)) dut (.clk(clk), .rst(rst), .cmd_strobe(cmd_strobe),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
        .irq_pin_master_enable(en), .irq_pin_edge_select(edge_sel),
        .clock_ready_evt(evt[0]), .host_suspended_evt(evt[1]), .op_register_evt(evt[2]),
        .async_list_evt(evt[3]), .frame_iso_list_evt(evt[4]), .end_of_transfer_pin(eot_pin),
        .xfer_start(evt[6]), .byte_strobe(evt[5]), .byte_count_limit(limit), .irq(irq),
        .cpu_event_status(status), .cpu_event_mask(mask));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One-cycle strobe on an event, counter start or byte input
    task automatic pulse(input int i);
        step(1);
        evt[i] = 1'b1;
        step(1);
        evt[i] = 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        host.rd(code, d, ok);
        chk_bit(ok, 1'b1);
        chk(d, exp);
    endtask

    // Bounded wait; running out ends the run
    task automatic wait_bit(input int b, input int lim);
        int k;
        k = 0;
        while (status[b] !== 1'b1 && k < lim) begin
            step(1);
            k++;
        end
        chk_bit(status[b], 1'b1);
        if (status[b] !== 1'b1) tally_and_finish();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        logic [15:0] d;
        logic        ok;
        logic [15:0] exp;
        int          n;
        rst = 1'b1;
        en = 1'b0;
        edge_sel = 1'b0;
        eot_pin = 1'b0;
        evt = 7'h00;
        limit = 16'h0000;
        fails = 0;
        compares = 0;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        chk({9'h000, status}, 16'h0000);
        chk({9'h000, mask}, 16'h0000);
        chk_bit(irq, 1'b0);
        rdchk(`HCIS_CMD_STATUS_RD, 16'h0000);
        rdchk(`HCIS_CMD_MASK_RD, 16'h0000);
        host.rd(8'h26, d, ok);
        chk_bit(ok, 1'b0);
        host.issue(`HCIS_CMD_MASK_WR, 16'hFFFF);
        rdchk(`HCIS_CMD_MASK_RD, 16'h0077);
        host.issue(`HCIS_CMD_MASK_WR, 16'h0000);
        // Flags build up; reads leave them, mask zero keeps the pin low
        en  = 1'b1;
        exp = 16'h0000;
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            exp = exp | flag_of(i);
            chk({9'h000, status}, exp);
            rdchk(`HCIS_CMD_STATUS_RD, exp);
            chk({9'h000, status}, exp);
            chk_bit(irq, 1'b0);
        end
        host.issue(`HCIS_CMD_STATUS_WR, 16'hFF08);
        chk({9'h000, status}, 16'h0073);
        host.issue(`HCIS_CMD_STATUS_WR, 16'h0010);
        chk({9'h000, status}, 16'h0063);
        host.clear_all();
        chk({9'h000, status}, 16'h0000);
        // Internal end only on the last counted byte, then the external pin
        limit = 16'h0003;
        pulse(6);
        pulse(5);
        pulse(5);
        step(4);
        chk_bit(status[2], 1'b0);
        pulse(5);
        wait_bit(2, 6);
        host.clear_all();
        eot_pin = 1'b1;
        wait_bit(2, 6);
        eot_pin = 1'b0;
        host.clear_all();
        // Pin gating by master enable and per-flag mask
        host.issue(`HCIS_CMD_MASK_WR, 16'h0001);
        en = 1'b0;
        pulse(4);
        step(3);
        chk_bit(irq, 1'b0);
        en = 1'b1;
        step(2);
        chk_bit(irq, 1'b1);
        host.issue(`HCIS_CMD_MASK_WR, 16'h0002);
        step(2);
        chk_bit(irq, 1'b0);
        pulse(3);
        step(2);
        chk_bit(irq, 1'b1);
        host.clear_all();
        step(2);
        chk_bit(irq, 1'b0);
        // Edge mode gives a single one-cycle pulse per request rise
        edge_sel = 1'b1;
        pulse(3);
        n = 0;
        repeat (6) begin
            if (irq === 1'b1) n++;
            step(1);
        end
        chk(n[15:0], 16'h0001);
        // A set landing with its own clear must win
        pulse(4);
        fork
            host.issue(`HCIS_CMD_STATUS_WR, 16'h0001);
            pulse(4);
        join
        chk_bit(status[0], 1'b1);
        host.issue(`HCIS_CMD_STATUS_WR, 16'h0001);
        chk_bit(status[0], 1'b0);
        // Reset in mid-run drops flags and masks at once
        host.issue(`HCIS_CMD_MASK_WR, 16'h0041);
        rdchk(`HCIS_CMD_MASK_RD, 16'h0041);
        pulse(0);
        rst = 1'b1;
        step(2);
        chk({9'h000, status}, 16'h0000);
        chk({9'h000, mask}, 16'h0000);
        chk_bit(irq, 1'b0);
        rst = 1'b0;
        pulse(0);
        step(2);
        chk({9'h000, status}, 16'h0040);
        chk_bit(irq, 1'b0);
        rdchk(`HCIS_CMD_MASK_RD, 16'h0000);
        tally_and_finish();
    end
endmodule // test_hcis_event_ctrl
